// ---- inc/slps_defines.svh ----
`ifndef SLPS_DEFINES_SVH
`define SLPS_DEFINES_SVH

`define SLPS_AW 24
`define SLPS_IW 48
`define SLPS_CW 32
`define SLPS_NOP_WORD 48'h000000000000
`define SLPS_CNT_ONE 32'h00000001
`define SLPS_LEN_FOUR 3'h4
`define SLPS_MIN_ITER_ONE 32'h00000004
`define SLPS_MIN_ITER_TWO 32'h00000002
`define SLPS_EXIT_DELAY_ONE 2'h2
`define SLPS_BUF_INIT 48'h000000000000

`endif

// ---- inc/slps_pkg.sv ----
`include "slps_defines.svh"

package slps_pkg;

    typedef struct packed {
        logic valid;
        logic [`SLPS_AW-1:0] addr;
        logic [`SLPS_IW-1:0] word;
    } slps_slot_t;

    typedef struct packed {
        logic pc_pop;
        logic loop_pop;
    } slps_pop_t;

    typedef enum logic [2:0] {
        SLPS_IDLE = 3'b000,
        SLPS_STALL = 3'b001,
        SLPS_RUN = 3'b010,
        SLPS_DRAIN = 3'b011,
        SLPS_EXIT = 3'b100
    } slps_state_t;

endpackage

// ---- rtl/slps_ibuf.sv ----
`timescale 1ns/1ps

// ********************************
// instruction buffer for loop body top
// ********************************
module slps_ibuf (
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic load_i,
    input wire slps_pkg::slps_slot_t slot_i,
    output slps_pkg::slps_slot_t slot_o
);
    import slps_pkg::*;

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            slot_o <= '0;
        end else if (load_i) begin
            slot_o <= slot_i;
        end
    end
endmodule

// ---- rtl/slps_sequencer.sv ----
`timescale 1ns/1ps
`include "slps_defines.svh"

// Contract
// - one-instr loop: fetch n+1 next, lock body n+1 in decode.
// - two-instr loop: fetch n+2 next after loop start in address.
// - three-instr loop: fetch n+1 next, no decode stall.
// - one, two, four-instr loops stall decode one cycle.
// - one-instr loop keeps body in decode, refetches it each cycle.
// - expiry tested when last instruction of final pass fetched.
// - cycle after expiry: abort loop-back, pop both stacks, fetch exit.
// - one-instr single pass: expiry cycle 3, exit cycle 5.
// - two-instr three passes: fetch n+1 in cycle 3.
// - two-instr loop-back feeds buffered n+1 into decode.
// - loop-back address comes from top of program-counter stack.
// - two-instr two passes: expiry cycle 3, buffered n+1 cycle 4.
// - three-instr single pass: expiry cycle 4, exit cycle 5.
// - below minimum count, up to three aborted cycles follow.
// - loop start loads buffer with the following instruction.
// - counter decrements once per pass at end-instruction fetch.
module slps_sequencer (
    input wire logic clock_i,
    input wire logic sys_rst_i,
    input wire logic [`SLPS_AW-1:0] fetch_addr_seq_i,
    input wire logic [`SLPS_IW-1:0] fetch_word_i,
    input wire logic addr_is_loop_start_i,
    input wire logic [2:0] addr_loop_len_i,
    input wire logic [`SLPS_CW-1:0] loop_count_load_i,
    input wire logic [`SLPS_AW-1:0] pc_stack_top_i,
    output logic [`SLPS_AW-1:0] fetch_addr_o,
    output slps_pkg::slps_slot_t decode_slot_o,
    output slps_pkg::slps_slot_t address_slot_o,
    output slps_pkg::slps_slot_t execute_slot_o,
    output logic decode_stall_o,
    output logic loop_counter_expired_o,
    output slps_pkg::slps_pop_t stack_pop_o,
    output logic [`SLPS_CW-1:0] current_iteration_counter_o
);
    import slps_pkg::*;

    // ********************************
    // state and pipeline registers
    // ********************************
    slps_state_t state;
    slps_state_t next_state;
    slps_slot_t fetch1;
    slps_slot_t fetch2;
    slps_slot_t decode;
    slps_slot_t address;
    slps_slot_t execute;
    slps_slot_t buf_slot;
    logic [2:0] len;
    logic [1:0] phase;
    logic single;
    logic [`SLPS_CW-1:0] cnt;
    logic [`SLPS_AW-1:0] base;
    logic expired;

    function automatic logic [`SLPS_AW-1:0] offs(
        input logic [`SLPS_AW-1:0] a,
        input logic [2:0] k
    );
        offs = a + {{(`SLPS_AW-3){1'b0}}, k};
    endfunction

    // ********************************
    // decode of the current cycle
    // ********************************
    wire start_w = addr_is_loop_start_i && address.valid && state == SLPS_IDLE;
    wire short_stall_w = addr_loop_len_i != 3'h3;
    wire one_w = len == 3'h1;
    wire two_w = len == 3'h2;
    wire three_w = len == 3'h3;
    wire odd_len_w = addr_loop_len_i == 3'h1 || addr_loop_len_i == 3'h3;
    wire long_w = len > 3'h3;
    // last-of-pass fetch: short bodies go by pass timing, long by address
    wire [`SLPS_AW-1:0] last_addr_w = offs(base, len);
    wire long_last_w = long_w && fetch_addr_o == last_addr_w;
    wire last_fetch_w = (state == SLPS_RUN && (one_w
        || (two_w && phase == 2'h0)
        || (three_w && phase == 2'h2)
        || (three_w && phase == 2'h0 && cnt == '0)
        || long_last_w))
        || (state == SLPS_STALL && long_last_w);
    // short bodies test an early count so long runs lose no cycles
    wire short_test_w = cnt == `SLPS_MIN_ITER_TWO
        || (two_w && cnt == `SLPS_CNT_ONE)
        || (three_w && cnt == '0);
    wire one_test_w = cnt == `SLPS_CNT_ONE || cnt == `SLPS_MIN_ITER_ONE;
    wire test_w = one_w ? one_test_w
        : (two_w || three_w) ? short_test_w : cnt == `SLPS_CNT_ONE;
    wire expire_now_w = last_fetch_w && test_w;
    // a single one-instr pass waits one more cycle before leaving
    wire slow_exit_w = one_w && single;
    wire [`SLPS_AW-1:0] exit_addr_w = offs(base, len + 3'h1);
    wire hold_w = state == SLPS_RUN && one_w;
    wire swap_w = two_w && fetch2.valid && fetch2.addr == offs(base, 3'h3)
        && state != SLPS_IDLE;

    // ********************************
    // fetch address select
    // ********************************
    always_comb begin
        next_state = state;
        fetch_addr_o = fetch_addr_seq_i;
        if (start_w) begin
            if (addr_loop_len_i == 3'h2) begin
                fetch_addr_o = offs(address.addr, 3'h2);
            end else if (odd_len_w) begin
                fetch_addr_o = offs(address.addr, 3'h1);
            end
            next_state = (addr_loop_len_i <= `SLPS_LEN_FOUR && short_stall_w)
                ? SLPS_STALL : SLPS_RUN;
        end else if (state == SLPS_EXIT) begin
            fetch_addr_o = exit_addr_w;
            next_state = SLPS_IDLE;
        end else if (state != SLPS_IDLE) begin
            if (one_w) begin
                fetch_addr_o = offs(base, 3'h1);
            end else if (state == SLPS_STALL) begin
                // stalled fetch repeats the word held in fetch1
                fetch_addr_o = fetch1.addr;
            end else if (fetch_addr_seq_i == exit_addr_w) begin
                fetch_addr_o = pc_stack_top_i;
            end
            if (state == SLPS_STALL) begin
                next_state = SLPS_RUN;
            end
            if (expired || (expire_now_w && !slow_exit_w)) begin
                next_state = SLPS_EXIT;
            end
        end
    end

    assign decode_stall_o = state == SLPS_STALL || hold_w;
    assign loop_counter_expired_o = expired;
    assign stack_pop_o.pc_pop = state == SLPS_EXIT;
    assign stack_pop_o.loop_pop = state == SLPS_EXIT;
    assign current_iteration_counter_o = cnt;
    assign decode_slot_o = decode;
    assign address_slot_o = address;
    assign execute_slot_o = execute;

    slps_slot_t fetched_w;
    assign fetched_w = '{valid: 1'b1, addr: fetch_addr_o, word: fetch_word_i};

    // ********************************
    // counter and state
    // ********************************
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            state <= SLPS_IDLE;
            cnt <= '0;
            len <= '0;
            base <= '0;
            expired <= 1'b0;
            phase <= '0;
            single <= 1'b0;
        end else begin
            state <= next_state;
            expired <= expire_now_w;
            if (start_w) begin
                cnt <= loop_count_load_i;
                len <= addr_loop_len_i;
                base <= address.addr;
                single <= loop_count_load_i == `SLPS_CNT_ONE;
            end else if (last_fetch_w && !expired && cnt != '0) begin
                cnt <= cnt - `SLPS_CNT_ONE;
            end
            // pass position for two and three word bodies
            if (start_w) begin
                phase <= 2'h1;
            end else if (phase == len[1:0] - 2'h1) begin
                phase <= 2'h0;
            end else begin
                phase <= phase + 2'h1;
            end
        end
    end

    // ********************************
    // pipeline stages
    // ********************************
    // aborted slots turn into bubbles so no stale body runs twice
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            fetch1 <= '0;
            fetch2 <= '0;
            decode <= '0;
            address <= '0;
            execute <= '0;
        end else begin
            execute <= address;
            fetch1 <= fetched_w;
            if (state == SLPS_EXIT || expired) begin
                fetch2 <= '0;
                decode <= '0;
                address <= decode_stall_o ? '0 : decode;
            end else if (start_w && addr_loop_len_i == 3'h1) begin
                // body word locks in decode while it also moves on
                address <= decode;
                fetch2 <= fetch1;
            end else if (decode_stall_o) begin
                address <= '0;
                // the start stall freezes fetch2; fetch1 reloads the repeated fetch
                fetch2 <= (state == SLPS_STALL) ? fetch2 : fetch1;
            end else begin
                address <= decode;
                fetch2 <= fetch1;
                decode <= swap_w ? buf_slot : fetch2;
            end
        end
    end

    slps_ibuf u_ibuf (
        .clock_i(clock_i),
        .sys_rst_i(sys_rst_i),
        .load_i(start_w),
        .slot_i(decode),
        .slot_o(buf_slot)
    );

    // ********************************
    // checks
    // ********************************
    sequence s_start;
        start_w;
    endsequence

    a_stall_after_start: assert property (@(posedge clock_i)
        disable iff (sys_rst_i)
        s_start ##0 short_stall_w |=> decode_stall_o)
        else $error("decode did not stall after loop start");

    a_three_no_stall: assert property (@(posedge clock_i)
        disable iff (sys_rst_i)
        s_start ##0 addr_loop_len_i == 3'h3 |=> !decode_stall_o)
        else $error("three loop stalled");

    a_one_fetch_addr: assert property (@(posedge clock_i)
        disable iff (sys_rst_i)
        s_start ##0 addr_loop_len_i == 3'h1
        |-> fetch_addr_o == offs(address.addr, 3'h1))
        else $error("one loop fetch address wrong");

    a_two_fetch_addr: assert property (@(posedge clock_i)
        disable iff (sys_rst_i)
        s_start ##0 addr_loop_len_i == 3'h2
        |-> fetch_addr_o == offs(address.addr, 3'h2))
        else $error("two loop fetch address wrong");

    a_pop_after_expiry: assert property (@(posedge clock_i)
        disable iff (sys_rst_i)
        expire_now_w && !slow_exit_w
        |=> stack_pop_o.pc_pop && stack_pop_o.loop_pop)
        else $error("stacks not popped after expiry");

    a_pop_slow_exit: assert property (@(posedge clock_i)
        disable iff (sys_rst_i)
        expire_now_w && slow_exit_w
        |=> ##1 stack_pop_o.pc_pop && stack_pop_o.loop_pop)
        else $error("single pass exit not popped");

    a_expiry_at_last: assert property (@(posedge clock_i)
        disable iff (sys_rst_i)
        expire_now_w |-> last_fetch_w)
        else $error("expiry outside last fetch");

    a_count_steps: assert property (@(posedge clock_i)
        disable iff (sys_rst_i)
        last_fetch_w && !expired && !start_w && cnt != '0
        |=> cnt == $past(cnt) - `SLPS_CNT_ONE)
        else $error("counter did not step");

    a_buffer_load: assert property (@(posedge clock_i)
        disable iff (sys_rst_i)
        start_w |=> buf_slot == $past(decode))
        else $error("buffer not loaded");

    a_exit_addr: assert property (@(posedge clock_i)
        disable iff (sys_rst_i)
        stack_pop_o.pc_pop |-> fetch_addr_o == exit_addr_w)
        else $error("exit fetch address wrong");
endmodule

// ---- sim/tb_top.sv ----
`timescale 1ns/1ps
`include "slps_defines.svh"

module tb_top;
    import slps_pkg::*;
    logic clock_i;
    logic sys_rst_i;
    logic [`SLPS_AW-1:0] fetch_addr_seq_i = 24'h000000;
    logic [`SLPS_AW-1:0] fetch_addr_o;
    logic [`SLPS_AW-1:0] pc_stack_top_i;
    logic [`SLPS_AW-1:0] base;
    logic [`SLPS_IW-1:0] fetch_word_i;
    logic addr_is_loop_start_i;
    logic decode_stall_o;
    logic loop_counter_expired_o;
    logic [2:0] addr_loop_len_i;
    logic [`SLPS_CW-1:0] loop_count_load_i;
    logic [`SLPS_CW-1:0] current_iteration_counter_o;
    slps_slot_t decode_slot_o;
    slps_slot_t address_slot_o;
    slps_slot_t execute_slot_o;
    slps_pop_t stack_pop_o;
    int fails;
    int checks_done;
    int cyc;
    int exp_at;

    // ********************************
    // environment: memory, pc logic, loop-start decode
    // ********************************
    // word tags its own address so a buffered word is recognisable
    assign fetch_word_i = {24'hC30000, fetch_addr_o};
    assign addr_is_loop_start_i = address_slot_o.valid &&
        (address_slot_o.addr == base);

    always @(posedge clock_i) begin
        fetch_addr_seq_i <= sys_rst_i ? 24'h000000 : fetch_addr_o + 24'h000001;
    end

    initial begin
        clock_i = 1'b0;
        forever #12.5 clock_i = ~clock_i;
    end

    slps_sequencer i_dut (
        .clock_i(clock_i),
        .sys_rst_i(sys_rst_i),
        .fetch_addr_seq_i(fetch_addr_seq_i),
        .fetch_word_i(fetch_word_i),
        .addr_is_loop_start_i(addr_is_loop_start_i),
        .addr_loop_len_i(addr_loop_len_i),
        .loop_count_load_i(loop_count_load_i),
        .pc_stack_top_i(pc_stack_top_i),
        .fetch_addr_o(fetch_addr_o),
        .decode_slot_o(decode_slot_o),
        .address_slot_o(address_slot_o),
        .execute_slot_o(execute_slot_o),
        .decode_stall_o(decode_stall_o),
        .loop_counter_expired_o(loop_counter_expired_o),
        .stack_pop_o(stack_pop_o),
        .current_iteration_counter_o(current_iteration_counter_o)
    );

    // ********************************
    // shared tasks
    // ********************************
    task automatic final_report;
        $display("checks_done=%0d fails=%0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic check(input logic [47:0] seen, input logic [47:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic step;
        @(posedge clock_i);
        #1;
        cyc++;
    endtask

    // loop start sits a few words ahead so it reaches address stage
    task automatic setup(input logic [2:0] len, input logic [31:0] cnt);
        @(posedge clock_i);
        addr_loop_len_i <= len;
        loop_count_load_i <= cnt;
        pc_stack_top_i <= fetch_addr_o + 24'h000007;
        base <= fetch_addr_o + 24'h000006;
        for (int i = 0; i < 40; i++) begin
            step();
            if (addr_is_loop_start_i === 1'b1) begin
                cyc = 1;
                return;
            end
        end
        fails++;
        final_report();
    endtask

    task automatic wait_exit(input logic [2:0] len, input logic slow);
        for (int i = 0; i < 80; i++) begin
            if (loop_counter_expired_o === 1'b1) begin
                exp_at = cyc;
                if (slow) begin
                    check(48'(stack_pop_o), 48'h0);
                    step();
                end
                check(48'(stack_pop_o), 48'h3);
                check(48'(fetch_addr_o), 48'(base + len + 1));
                step();
                check(48'(stack_pop_o), 48'h0);
                return;
            end
            step();
        end
        fails++;
        final_report();
    endtask

    // ********************************
    // scenarios
    // ********************************
    task automatic t_one_single;
        setup(3'h1, 32'h1);
        check(48'(fetch_addr_o), 48'(base + 1));
        step();
        check(48'(decode_stall_o), 48'h1);
        step();
        step();
        check(48'(execute_slot_o.valid), 48'h0);
        wait_exit(3'h1, 1'b1);
        check(48'(exp_at), 48'h4);
    endtask

    task automatic t_one_multi;
        setup(3'h1, 32'h5);
        check(48'(fetch_addr_o), 48'(base + 1));
        step();
        check(48'(decode_stall_o), 48'h1);
        repeat (2) begin
            step();
            check(48'(fetch_addr_o), 48'(base + 1));
            check(48'(decode_slot_o.addr), 48'(base + 1));
        end
        wait_exit(3'h1, 1'b0);
    endtask

    task automatic t_two_twice;
        setup(3'h2, 32'h2);
        check(48'(fetch_addr_o), 48'(base + 2));
        step();
        check(48'(decode_stall_o), 48'h1);
        step();
        step();
        check(48'(decode_slot_o.addr), 48'(base + 1));
        check(decode_slot_o.word, {24'hC30000, base + 24'h1});
        wait_exit(3'h2, 1'b0);
        check(48'(exp_at), 48'h4);
    endtask

    task automatic t_two_thrice;
        setup(3'h2, 32'h3);
        step();
        step();
        check(48'(fetch_addr_o), 48'(pc_stack_top_i));
        wait_exit(3'h2, 1'b0);
        // one more pass of two words puts expiry two cycles later
        check(48'(exp_at), 48'h6);
    endtask

    task automatic t_three_once;
        setup(3'h3, 32'h1);
        check(48'(fetch_addr_o), 48'(base + 1));
        step();
        check(48'(decode_stall_o), 48'h0);
        wait_exit(3'h3, 1'b0);
        check(48'(exp_at), 48'h5);
    endtask

    task automatic t_four;
        setup(3'h4, 32'h1);
        step();
        check(48'(decode_stall_o), 48'h1);
        wait_exit(3'h4, 1'b0);
    endtask

    initial begin
        sys_rst_i = 1'b1;
        addr_loop_len_i = 3'h1;
        loop_count_load_i = 32'h1;
        pc_stack_top_i = 24'h000000;
        base = 24'hFFFFFF;
        fails = 0;
        checks_done = 0;
        repeat (4) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        t_one_single();
        t_one_multi();
        t_two_twice();
        t_two_thrice();
        t_three_once();
        t_four();
        final_report();
    end
endmodule
